// ==== verilog/ssio_map_top.sv ====
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - four output terminals, each with its own function code selecting its source.
// - code 1 drives the output on unconditionally.
// - code 2 on with power normal and no alarm; code 3 off on alarm.
// - code 4 on when speed magnitude below zero-speed threshold in speed/torque mode.
// - code 5 on when position deviation below in-position threshold in position mode.
// - code 6 on when speed above arrival threshold, speed/torque mode, polarity selectable.
// - code 7 on when torque above arrival threshold, polarity selectable.
// - code 8 on while the brake is to be released.
// - code 9 on while the motor is energized and running.
// - code 10 on when position deviation below near threshold in position mode.
// - code 11 on while torque sits at its configured limit.
// - code 12 on in torque mode while speed has reached its limit.
// - code 13 on when actual minus commanded speed magnitude below match threshold.
// - code 15 on once homing has completed.
// - code 16 on after completion delay once a segment completes or stops.
// - code 18 follows the encoder index signal.
// - five 8-bit force words, each used bit one input function.
// - word a: enable, alarm clear, limits, torque direction, zero lock, command zero.
// - word b: invert, speed select, torque limit select, mode switch; bits 3,6 unused.
// - word c: ratio select, pulse clear, pulse block, jogs; bits 0,7 unused.
// - word d: hold, trigger, segment select; word e: homing start, origin latch.
// - force 1 makes function effective; 0 follows assigned terminal, else invalid.
module ssio_map_top
    import ssio_pkg::*;
#(
    parameter int unsigned DW = 16, // width of speed, torque and position values
    parameter int unsigned MS_CYCLES = CYCLES_PER_MS // clock cycles per ms of delay
) (
    input wire logic ref_clk, // block clock, 250 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic hsel, // bus slave select
    input wire logic [31:0] haddr, // bus byte address
    input wire logic [1:0] htrans, // bus transfer type
    input wire logic hwrite, // bus write flag
    input wire logic [2:0] hsize, // bus transfer size, words only
    input wire logic [31:0] hwdata, // bus write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // bus ready out
    output logic [31:0] hrdata, // bus read data
    output logic hresp, // bus response, always okay
    input wire logic [3:0] inTerm, // input terminal levels
    input wire logic mainPowerOk, // main supply normal
    input wire logic alarmActive, // drive alarm present
    input wire logic [1:0] ctrlMode, // control mode from motion core
    input wire logic signed [DW-1:0] motorSpeed, // actual speed
    input wire logic signed [DW-1:0] speedCmd, // commanded speed
    input wire logic signed [DW-1:0] positionDev, // position deviation
    input wire logic signed [DW-1:0] motorTorque, // motor torque
    input wire logic [DW-1:0] zeroSpeedThreshold, // zero speed level
    input wire logic [DW-1:0] inPositionThreshold, // in position window
    input wire logic [DW-1:0] speedArrivalThreshold, // speed arrival level
    input wire logic [DW-1:0] torqueArrivalThreshold, // torque arrival level
    input wire logic [DW-1:0] nearPositionThreshold, // near position window
    input wire logic [DW-1:0] speedMatchThreshold, // speed match window
    input wire logic [DW-1:0] speedLimitSetting, // speed limit in torque mode
    input wire logic torqueAtLimit, // torque clamped by its limit
    input wire logic brakeRelease, // brake to be released
    input wire logic motorEnergized, // motor powered and running
    input wire logic homeDone, // home return completed
    input wire logic segmentEnd, // segment completed or stopped
    input wire logic indexPulse, // encoder index valid
    output logic [3:0] outTerm, // output terminal levels
    output logic [NUM_FUNCS-1:0] effFunc // effective input functions
);
    ssio_state_t st_reg;
    ssio_state_t st_next;
    ssio_flag_if flagBus();
    logic [3:0] selOut;
    logic timerDone;
    logic speedMode;
    logic posMode;
    logic trqMode;
    logic [DW-1:0] speedMag;
    logic [DW:0] diffMag;

    // magnitude of a signed value, one bit wider so the most negative value fits
    function automatic logic [DW:0] absv(input logic signed [DW:0] v);
        absv = v[DW] ? -v : v;
    endfunction

    // read multiplexer; unmapped words read as zero
    function automatic logic [31:0] regRead(input ssio_state_t s, input logic [7:0] a, input logic [3:0] t);
        regRead = 32'h0000_0000;
        case (a)
            OFF_FORCE_A, OFF_FORCE_B, OFF_FORCE_C, OFF_FORCE_D, OFF_FORCE_E: begin
                regRead = {24'h00_0000, s.forceVec[a[4:2]*8 +: 8]};
            end
            8'h14, 8'h18, 8'h1C, OFF_OUT_CODE3: begin
                regRead = {27'h000_0000, s.outCode[2'(a[4:2] - 3'h5)]};
            end
            OFF_IN_ASSIGN: begin
                regRead = s.inAssign;
            end
            OFF_CONFIG: begin
                regRead = {16'h0000, s.completionDelay, 6'h00, s.torquePol, s.speedPol};
            end
            OFF_STATUS: begin
                regRead = {24'h00_0000, t, s.outTerm};
            end
            OFF_EFF_LO: begin
                regRead = s.effFunc[31:0];
            end
            OFF_EFF_HI: begin
                regRead = {24'h00_0000, s.effFunc[39:32]};
            end
            default: begin
                regRead = 32'h0000_0000;
            end
        endcase
    endfunction

    // mode gates; other modes leave the mode-bound outputs off
    assign posMode = (ctrlMode == MODE_POSITION);
    assign speedMode = (ctrlMode == MODE_SPEED);
    assign trqMode = (ctrlMode == MODE_TORQUE);
    assign speedMag = DW'(absv({motorSpeed[DW-1], motorSpeed}));
    assign diffMag = absv((DW+1)'({motorSpeed[DW-1], motorSpeed} - {speedCmd[DW-1], speedCmd}));

    // condition flags per output function code, unused codes stay zero
    always_comb begin
        flagBus.cond = '0;
        flagBus.cond[OC_ALWAYS_ON] = 1'b1;
        flagBus.cond[OC_SERVO_READY] = mainPowerOk && !alarmActive;
        flagBus.cond[OC_FAULT_FREE] = !alarmActive;
        flagBus.cond[OC_ZERO_SPEED] = (speedMode || trqMode) && (speedMag < zeroSpeedThreshold);
        flagBus.cond[OC_POS_DONE] = posMode
            && (DW'(absv({positionDev[DW-1], positionDev})) < inPositionThreshold);
        // polarity bit inverts the compare, the mode gate stays in force
        flagBus.cond[OC_SPEED_REACHED] = (speedMode || trqMode)
            && ((speedMag > speedArrivalThreshold) ^ st_reg.speedPol);
        flagBus.cond[OC_TORQUE_REACHED] = (DW'(absv({motorTorque[DW-1], motorTorque})) > torqueArrivalThreshold)
            ^ st_reg.torquePol;
        flagBus.cond[OC_BRAKE_RELEASE] = brakeRelease;
        flagBus.cond[OC_RUNNING] = motorEnergized;
        flagBus.cond[OC_NEAR_POS] = posMode
            && (DW'(absv({positionDev[DW-1], positionDev})) < nearPositionThreshold);
        flagBus.cond[OC_TORQUE_LIMITED] = torqueAtLimit;
        flagBus.cond[OC_SPEED_LIMITED] = trqMode && (speedMag >= speedLimitSetting);
        flagBus.cond[OC_SPEED_MATCH] = diffMag < {1'b0, speedMatchThreshold};
        flagBus.cond[OC_HOME_DONE] = homeDone;
        flagBus.cond[OC_SEGMENT_DONE] = timerDone;
        flagBus.cond[OC_INDEX_PULSE] = indexPulse;
    end

    // one selector per output terminal
    for (genvar g = 0; g < NUM_OUT_TERMS; g++) begin : gSel
        ssio_out_select uSel (
            .flags(flagBus.sink),
            .code(st_reg.outCode[g]),
            .sel(selOut[g])
        );
    end

    // segment completion delay, counted in ms of clock
    ssio_delay_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) uTimer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .segEnd(segmentEnd),
        .delayMs(st_reg.completionDelay),
        .done(timerDone)
    );

    // bus slave and registers: one wait state so read data comes from a flop
    always_comb begin
        logic termHit;
        termHit = 1'b0;
        st_next = st_reg;
        st_next.hreadyout = 1'b1;
        if (st_reg.pend) begin
            st_next.pend = 1'b0;
            st_next.hrdata = 32'h0000_0000;
            if (st_reg.pendHit && !st_reg.pendWrite) begin
                st_next.hrdata = regRead(st_reg, st_reg.pendAddr, inTerm);
            end
            if (st_reg.pendHit && st_reg.pendWrite) begin
                case (st_reg.pendAddr)
                    OFF_FORCE_A, OFF_FORCE_B, OFF_FORCE_C, OFF_FORCE_D, OFF_FORCE_E: begin
                        st_next.forceVec[st_reg.pendAddr[4:2]*8 +: 8] = hwdata[7:0];
                    end
                    8'h14, 8'h18, 8'h1C, OFF_OUT_CODE3: begin
                        st_next.outCode[2'(st_reg.pendAddr[4:2] - 3'h5)] = hwdata[4:0];
                    end
                    OFF_IN_ASSIGN: begin
                        st_next.inAssign = hwdata;
                    end
                    OFF_CONFIG: begin
                        st_next.speedPol = hwdata[CFG_SPEED_POL];
                        st_next.torquePol = hwdata[CFG_TORQUE_POL];
                        st_next.completionDelay = hwdata[CFG_DELAY_LSB +: 8];
                    end
                    default: begin
                        st_next.hrdata = 32'h0000_0000; // read-only or unmapped: write ignored
                    end
                endcase
            end
        end else if (hsel && htrans[1] && hready) begin
            st_next.pend = 1'b1;
            st_next.pendWrite = hwrite;
            st_next.pendAddr = haddr[7:0];
            st_next.pendHit = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
            st_next.hreadyout = 1'b0;
        end
        // effective input functions; unused positions are masked on both paths
        for (int i = 0; i < NUM_FUNCS; i++) begin
            termHit = 1'b0;
            for (int k = 0; k < NUM_IN_TERMS; k++) begin
                if (st_reg.inAssign[k][ASSIGN_EN] && (st_reg.inAssign[k][5:0] == 6'(i)) && inTerm[k]) begin
                    termHit = 1'b1;
                end
            end
            st_next.effFunc[i] = FUNC_USED_MASK[i] && (st_reg.forceVec[i] || termHit);
        end
        st_next.outTerm = selOut;
        if (!rst_n) begin
            st_next = SSIO_STATE_RST;
        end
    end

    always_ff @(posedge ref_clk) begin
        st_reg <= st_next;
    end

    // every output but hresp straight from the state register; hresp tied to okay
    assign hreadyout = st_reg.hreadyout;
    assign hrdata = st_reg.hrdata;
    assign hresp = 1'b0;
    assign outTerm = st_reg.outTerm;
    assign effFunc = st_reg.effFunc;

    a_always_on_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.outCode[0] == OC_ALWAYS_ON) |=> outTerm[0])
        else $error("code 1 terminal not on");

    a_alarm_off_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.outCode[0] == OC_FAULT_FREE) |=> (outTerm[0] == !$past(alarmActive)))
        else $error("fault free terminal wrong");

    a_ready_needs_power: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.outCode[2] == OC_SERVO_READY) && !mainPowerOk |=> !outTerm[2])
        else $error("ready on without power");

    a_brake_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.outCode[1] == OC_BRAKE_RELEASE) |=> (outTerm[1] == $past(brakeRelease)))
        else $error("brake terminal wrong");

    a_zero_speed_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.outCode[3] == OC_ZERO_SPEED) && posMode |=> !outTerm[3])
        else $error("zero speed on in position mode");

    a_unlisted_code_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.outCode[1] == 5'h0E || st_reg.outCode[1] > OC_INDEX_PULSE) |=> !outTerm[1])
        else $error("unlisted code drives on");

    a_force_makes_valid: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_reg.forceVec[FN_SERVO_ENABLE] |=> effFunc[FN_SERVO_ENABLE])
        else $error("forced function not effective");

    a_unassigned_invalid: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !st_reg.forceVec[FN_HOMING_START] && !st_reg.inAssign[0][ASSIGN_EN] && !st_reg.inAssign[1][ASSIGN_EN]
        && !st_reg.inAssign[2][ASSIGN_EN] && !st_reg.inAssign[3][ASSIGN_EN] |=> !effFunc[FN_HOMING_START])
        else $error("unassigned function effective");

    a_unused_bit_inert: assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> !effFunc[11] && !effFunc[14] && !effFunc[16] && !effFunc[23])
        else $error("unused force bit took effect");

    a_reset_clears: assert property (@(posedge ref_clk)
        !rst_n |=> (outTerm == 4'h0) && (effFunc == 40'h00_0000_0000) && hreadyout)
        else $error("reset did not clear outputs");

    a_seg_zero_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (segmentEnd && st_reg.completionDelay == 8'h00) [*2] |=> timerDone)
        else $error("segment done late with zero delay");

    a_seg_drop_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !segmentEnd |=> !timerDone)
        else $error("segment done without segment end");

    a_wait_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !hreadyout |=> hreadyout)
        else $error("bus wait longer than one cycle");

    c_bus_write: cover property (@(posedge ref_clk) disable iff (!rst_n) st_reg.pend && st_reg.pendWrite);
    c_bus_read: cover property (@(posedge ref_clk) disable iff (!rst_n) st_reg.pend && !st_reg.pendWrite);
    c_seg_done: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(timerDone));
    c_term_follow: cover property (@(posedge ref_clk) disable iff (!rst_n) st_reg.inAssign[0][ASSIGN_EN] && inTerm[0]);
endmodule
`default_nettype wire

// ==== verilog/ssio_pkg.sv ====
`default_nettype none
package ssio_pkg;

    // register byte offsets on the bus, one aligned word each
    localparam logic [7:0] OFF_FORCE_A = 8'h00;
    localparam logic [7:0] OFF_FORCE_B = 8'h04;
    localparam logic [7:0] OFF_FORCE_C = 8'h08;
    localparam logic [7:0] OFF_FORCE_D = 8'h0C;
    localparam logic [7:0] OFF_FORCE_E = 8'h10;
    localparam logic [7:0] OFF_OUT_CODE0 = 8'h14;
    localparam logic [7:0] OFF_OUT_CODE3 = 8'h20;
    localparam logic [7:0] OFF_IN_ASSIGN = 8'h24;
    localparam logic [7:0] OFF_CONFIG = 8'h28;
    localparam logic [7:0] OFF_STATUS = 8'h2C;
    localparam logic [7:0] OFF_EFF_LO = 8'h30;
    localparam logic [7:0] OFF_EFF_HI = 8'h34;

    // field layout of the config word
    localparam int unsigned CFG_SPEED_POL = 0;
    localparam int unsigned CFG_TORQUE_POL = 1;
    localparam int unsigned CFG_DELAY_LSB = 8;
    // field layout of one input assignment byte
    localparam int unsigned ASSIGN_EN = 7;

    // counts: 5 force words of 8 bits, 4 output and 4 input terminals
    localparam int unsigned NUM_FORCE_WORDS = 5;
    localparam int unsigned NUM_FUNCS = NUM_FORCE_WORDS * 8;
    localparam int unsigned NUM_OUT_TERMS = 4;
    localparam int unsigned NUM_IN_TERMS = 4;
    localparam int unsigned NUM_CODES = 19;

    // input function bit positions, word a .. word e
    localparam int unsigned FN_SERVO_ENABLE = 0, FN_ALARM_CLEAR = 1, FN_REV_LIMIT = 2, FN_FWD_LIMIT = 3;
    localparam int unsigned FN_TORQUE_DIR_A = 4, FN_TORQUE_DIR_B = 5, FN_ZERO_LOCK = 6, FN_CMD_ZERO = 7;
    localparam int unsigned FN_CMD_INVERT = 8, FN_SPEED_SEL0 = 9, FN_SPEED_SEL1 = 10;
    localparam int unsigned FN_TRQ_LIM_SEL0 = 12, FN_TRQ_LIM_SEL1 = 13, FN_MODE_SWITCH = 15;
    localparam int unsigned FN_RATIO_SEL0 = 17, FN_RATIO_SEL1 = 18, FN_PULSE_CLEAR = 19;
    localparam int unsigned FN_PULSE_BLOCK = 20, FN_JOG_FWD = 21, FN_JOG_REV = 22;
    localparam int unsigned FN_HOLD = 26, FN_SEG_TRIGGER = 27, FN_SEG_SEL0 = 28, FN_SEG_SEL2 = 30;
    localparam int unsigned FN_HOMING_START = 32, FN_ORIGIN_LATCH = 33;
    // bits that carry a function; the rest of the force words are inert
    localparam logic [39:0] FUNC_USED_MASK = 40'h03_7C7E_B7FF;

    // output function codes
    localparam logic [4:0] OC_ALWAYS_ON = 5'h01, OC_SERVO_READY = 5'h02, OC_FAULT_FREE = 5'h03;
    localparam logic [4:0] OC_ZERO_SPEED = 5'h04, OC_POS_DONE = 5'h05, OC_SPEED_REACHED = 5'h06;
    localparam logic [4:0] OC_TORQUE_REACHED = 5'h07, OC_BRAKE_RELEASE = 5'h08, OC_RUNNING = 5'h09;
    localparam logic [4:0] OC_NEAR_POS = 5'h0A, OC_TORQUE_LIMITED = 5'h0B, OC_SPEED_LIMITED = 5'h0C;
    localparam logic [4:0] OC_SPEED_MATCH = 5'h0D, OC_HOME_DONE = 5'h0F, OC_SEGMENT_DONE = 5'h10;
    localparam logic [4:0] OC_INDEX_PULSE = 5'h12;

    // control mode reported by the motion core
    typedef enum logic [1:0] {
        MODE_POSITION = 2'b00,
        MODE_SPEED = 2'b01,
        MODE_TORQUE = 2'b10
    } ssio_mode_t;

    // completion delay unit and its length in clock cycles
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned DELAY_UNIT_NS = 1000000;
    localparam int unsigned CYCLES_PER_MS = DELAY_UNIT_NS / CLK_PERIOD_NS;

    // all state of the top module
    typedef struct packed {
        logic [39:0] forceVec;
        logic [3:0][4:0] outCode;
        logic [3:0][7:0] inAssign;
        logic speedPol;
        logic torquePol;
        logic [7:0] completionDelay;
        logic [3:0] outTerm;
        logic [39:0] effFunc;
        logic pend;
        logic pendWrite;
        logic pendHit;
        logic [7:0] pendAddr;
        logic hreadyout;
        logic [31:0] hrdata;
    } ssio_state_t;

    localparam ssio_state_t SSIO_STATE_RST = '{hreadyout: 1'b1, default: '0};

endpackage
`default_nettype wire

// ==== verilog/ssio_flag_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// condition flags indexed by output function code
interface ssio_flag_if;
    logic [18:0] cond;
    modport src(output cond);
    modport sink(input cond);
endinterface
`default_nettype wire

// ==== verilog/ssio_out_select.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssio_out_select
    import ssio_pkg::*;
(
    ssio_flag_if.sink flags, // condition flags by code
    input wire logic [4:0] code, // function code of this terminal
    output logic sel // selected level, combinational
);
    // codes beyond the table fall to off; holes in the table are zero flags
    always_comb begin
        if (code < 5'(NUM_CODES)) begin
            sel = flags.cond[code];
        end else begin
            sel = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/ssio_delay_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssio_delay_timer
    import ssio_pkg::*;
#(
    parameter int unsigned MS_CYCLES = CYCLES_PER_MS
) (
    input wire logic ref_clk, // block clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic segEnd, // segment completed or stopped
    input wire logic [7:0] delayMs, // completion delay in ms
    output logic done // delay elapsed while segEnd held
);
    localparam int unsigned PW = $clog2(MS_CYCLES + 1);
    typedef struct packed {
        logic [PW-1:0] prescale;
        logic [7:0] msCount;
        logic done;
    } ssio_tmr_state_t;
    ssio_tmr_state_t st_reg;
    ssio_tmr_state_t st_next;

    // counts whole ms while the segment end is held; dropping it restarts
    always_comb begin
        st_next = st_reg;
        if (!segEnd) begin
            st_next = '0;
        end else if (!st_reg.done) begin
            if (st_reg.msCount >= delayMs) begin
                st_next.done = 1'b1;
            end else if (st_reg.prescale == PW'(MS_CYCLES - 1)) begin
                st_next.prescale = '0;
                st_next.msCount = st_reg.msCount + 8'h01;
            end else begin
                st_next.prescale = st_reg.prescale + PW'(1);
            end
        end
        if (!rst_n) begin
            st_next = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        st_reg <= st_next;
    end

    assign done = st_reg.done;
endmodule
`default_nettype wire

// ==== verification/ssio_term_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// machine logic on the discrete input terminals
module ssio_term_model (
    input wire logic ref_clk, // block clock
    input wire logic [3:0] want, // levels the machine asks for
    output var logic [3:0] inTerm = 4'h0 // input terminal levels
);
    // relay-like: one cycle late, so a change never lands on the sampling edge
    always @(posedge ref_clk) begin
        inTerm <= want;
    end
endmodule
`default_nettype wire

// ==== verification/servo_digital_io_function_map_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module servo_digital_io_function_map_tb;
    import ssio_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, segEnd = 1'b0;
    logic [1:0] htrans = 2'h0, ctrlMode = 2'h3;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, hrdata;
    logic [15:0] val = 16'h0000, cmd = 16'h0000, thr = 16'h0064, near = 16'h00C8;
    logic [6:0] flg = 7'h00; // power, alarm, torque limit, brake, energized, home, index
    logic [3:0] want = 4'h0, inTerm, outTerm;
    logic hreadyout, hresp;
    logic [39:0] effFunc;
    int failures = 0, nTests = 0;
    // code, mode, speed/torque/deviation value, flags, expected terminal level
    logic [30:0] rows [27] = '{
        {5'h01,2'h3,16'h0000,7'h00,1'h1}, {5'h02,2'h0,16'h0000,7'h40,1'h1}, {5'h02,2'h0,16'h0000,7'h60,1'h0},
        {5'h03,2'h0,16'h0000,7'h20,1'h0}, {5'h03,2'h0,16'h0000,7'h00,1'h1}, {5'h04,2'h1,16'hFFCE,7'h00,1'h1},
        {5'h04,2'h2,16'hFF6A,7'h00,1'h0}, {5'h04,2'h0,16'hFFCE,7'h00,1'h0}, {5'h05,2'h0,16'h0032,7'h00,1'h1},
        {5'h05,2'h0,16'h0096,7'h00,1'h0}, {5'h06,2'h1,16'h0096,7'h00,1'h1}, {5'h06,2'h2,16'h0032,7'h00,1'h0},
        {5'h07,2'h3,16'h0096,7'h00,1'h1}, {5'h08,2'h0,16'h0000,7'h08,1'h1}, {5'h09,2'h0,16'h0000,7'h04,1'h1},
        {5'h0A,2'h0,16'h0096,7'h00,1'h1}, {5'h0A,2'h1,16'h0032,7'h00,1'h0}, {5'h0B,2'h0,16'h0000,7'h10,1'h1},
        {5'h0C,2'h2,16'h0096,7'h00,1'h1}, {5'h0C,2'h1,16'h0096,7'h00,1'h0}, {5'h0D,2'h0,16'h0032,7'h00,1'h1},
        {5'h0D,2'h0,16'h0096,7'h00,1'h0}, {5'h0F,2'h0,16'h0000,7'h02,1'h1}, {5'h12,2'h0,16'h0000,7'h01,1'h1},
        {5'h12,2'h0,16'h0000,7'h00,1'h0}, {5'h0E,2'h0,16'h0000,7'h7F,1'h0}, {5'h11,2'h0,16'h0000,7'h7F,1'h0}};

    always #2 ref_clk = ~ref_clk;

    ssio_term_model PM (.ref_clk(ref_clk), .want(want), .inTerm(inTerm));
    // short ms so the completion delay fits the run
    ssio_map_top #(.DW(16), .MS_CYCLES(4)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .inTerm(inTerm), .mainPowerOk(flg[6]),
        .alarmActive(flg[5]), .ctrlMode(ctrlMode), .motorSpeed(val), .speedCmd(cmd), .positionDev(val),
        .motorTorque(val), .zeroSpeedThreshold(thr), .inPositionThreshold(thr), .speedArrivalThreshold(thr),
        .torqueArrivalThreshold(thr), .nearPositionThreshold(near), .speedMatchThreshold(thr),
        .speedLimitSetting(thr), .torqueAtLimit(flg[4]), .brakeRelease(flg[3]), .motorEnergized(flg[2]),
        .homeDone(flg[1]), .segmentEnd(segEnd), .indexPulse(flg[0]), .outTerm(outTerm), .effFunc(effFunc));

    task automatic chk(input logic [43:0] got, input logic [43:0] exp);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // one single word transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // rows rotate over the four terminals so each code register is used
    task automatic run_row(input logic [30:0] r, input int k);
        @(posedge ref_clk);
        ctrlMode <= r[25:24];
        val <= r[23:8];
        flg <= r[7:1];
        bus(1'b1, OFF_OUT_CODE0 + 8'(4 * k), {27'h000_0000, r[30:26]});
        repeat (2) @(negedge ref_clk);
        chk(outTerm[k], r[0]);
    endtask

    task finish_test;
        $display("failures %0d tests %0d", failures, nTests);
        if (failures == 0 && nTests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk({outTerm, effFunc}, 44'h000_0000_0000);
        foreach (rows[i]) run_row(rows[i], i % 4);
        // inverted polarity on codes 6 and 7; code 13 with a negative difference just inside the window
        @(posedge ref_clk);
        ctrlMode <= 2'h1;
        val <= 16'h0096;
        cmd <= 16'h00F9;
        bus(1'b1, OFF_OUT_CODE0, 32'h0000_0006);
        bus(1'b1, OFF_OUT_CODE0 + 8'h04, 32'h0000_0007);
        bus(1'b1, OFF_OUT_CODE0 + 8'h08, 32'h0000_000D);
        bus(1'b1, OFF_CONFIG, 32'h0000_0003);
        repeat (2) @(negedge ref_clk);
        chk(outTerm[2:0], 3'h4);
        // walk one force bit at a time; unused positions must stay inert
        for (int i = 0; i < 40; i++) begin
            if (i % 8 == 0 && i > 0) bus(1'b1, OFF_FORCE_A + 8'(4 * (i / 8 - 1)), 32'h0000_0000);
            bus(1'b1, OFF_FORCE_A + 8'(4 * (i / 8)), 32'(1 << (i % 8)));
            repeat (2) @(negedge ref_clk);
            chk(effFunc, 40'h03_7C7E_B7FF & (40'h1 << i));
        end
        bus(1'b0, OFF_FORCE_E, 32'h0000_0000);
        chk(rd, 32'h0000_0080);
        bus(1'b0, 8'hFC, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // terminal 1 carries origin latch, terminal 2 servo enable, terminal 3 disabled
        bus(1'b1, OFF_FORCE_E, 32'h0000_0000);
        bus(1'b1, OFF_IN_ASSIGN, 32'h0080_A180);
        want <= 4'hA;
        repeat (3) @(negedge ref_clk);
        chk(effFunc, 40'h02_0000_0000);
        @(posedge ref_clk);
        want <= 4'h4;
        repeat (3) @(negedge ref_clk);
        chk(effFunc, 40'h00_0000_0001);
        // segment done after a 1 ms completion delay
        bus(1'b1, OFF_OUT_CODE3, 32'h0000_0010);
        bus(1'b1, OFF_CONFIG, 32'h0000_0100);
        segEnd <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(outTerm[3], 1'b0);
        repeat (8) @(negedge ref_clk);
        chk(outTerm[3], 1'b1);
        @(posedge ref_clk);
        segEnd <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(outTerm[3], 1'b0);
        // zero delay: on two edges after the segment end
        bus(1'b1, OFF_CONFIG, 32'h0000_0000);
        segEnd <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(outTerm[3], 1'b1);
        // mid-run reset with terminals and functions on clears them and the registers
        @(posedge ref_clk);
        rst_n <= 1'b0;
        segEnd <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk({outTerm, effFunc}, 44'h000_0000_0000);
        bus(1'b0, OFF_IN_ASSIGN, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(hresp, 1'b0);
        finish_test();
    end

    // whole run needs well under 2000 cycles
    initial begin
        #40000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
